// File: logic/keyboard_transceiver.sv
// Purpose: Serial transceiver for the keyboard link, AXI4-Lite slave.
// Assumes: Inputs synchronous to clk; sys_rst synchronous, active high.
// Notes: One shared data word; reading it re-arms reception.
//
// How it works
// - Frames carry one start bit, eight data bits, two stop bits.
// - Least significant data bit goes first on the line, both ways.
// - Receiver samples the input on a tick sixteen times the bit rate.
// - A complete received byte raises the receive-available flag.
// - Start pulses shorter than half a bit are dropped.
// - Writing transmit data reloads, clears done, restarts, aborts any frame.
// - End of transmission raises the transmit-done flag.
// - Reading receive data returns last byte and clears receive flag.
// - One programmable divider sets the rate for both directions.
// - Receive flag rises at the middle of the last data bit.
// - Keyboard sends the next byte only after the host acknowledges.
// - Unexpected codes during restart handshake start it over.
// - Mouse data flows only after a mouse-enabling acknowledge.
// - Lamp and no-op act at once; reply commands wait their turn.
// - Repeated reply commands get a single reply.
// - Lamp field: bit 0 caps, bit 1 number, bit 2 scroll.
// - Type request 0x20 answered by 10 plus six-bit type code.
// - Echo request 0100xxxx answered by 1110xxxx.
// - Restart code 0xFF; handshake replies 0xFE then 0xFD.
// - Data bits travel inverted on the wire.
// - Acknowledge codes 0x3F and 0x30 to 0x33.
// - Pointer request 0x22 and no-op 0x21, single bytes.
// - Lamp command is 00000 over a three-bit lamp field.

`timescale 1ns/10ps

module keyboard_transceiver
	import keyboard_serial_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite write address channel
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address channel
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial link
	input wire logic serial_in_pin,
	output logic serial_out_pin
);

	initial begin
		if (ADDR_W < 4) begin
			$error("ADDR_W must be at least 4");
		end
	end

	// ==========================================================
	// State
	// ==========================================================
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_type;
	typedef enum logic {TX_IDLE, TX_RUN} tx_state_type;

	typedef struct packed {
		logic [15:0] baud_div;
		logic [15:0] tick_cnt;
		rx_state_type rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic [7:0] rx_data;
		logic rx_flag;
		logic rx_armed;
		tx_state_type tx_st;
		logic [3:0] tx_sub;
		logic [3:0] tx_bit;
		logic [FRAME_BITS-1:0] tx_shift;
		logic tx_done;
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	state_type st_r;
	state_type st_nxt;

	// Classifies the held receive byte for restart and reply handling.
	function automatic logic [2:0] classify(input logic [7:0] b);
		logic [2:0] c;
		c = 3'h0;
		c[0] = (b == hard_restart_code);
		c[1] = (b[7:6] == type_code_reply);
		c[2] = (b[7:4] == echo_reply);
		return c;
	endfunction

	// ==========================================================
	// Next state
	// ==========================================================
	logic tick;
	logic do_write;
	logic do_read;
	logic [3:0] rd_addr;
	logic [2:0] cls;

	always_comb begin
		st_nxt = st_r;
		rd_addr = araddr[3:0];
		cls = classify(st_r.rx_data);

		// Oversampling tick shared by both directions.
		tick = (st_r.tick_cnt == 16'h0000);
		if (tick) begin
			st_nxt.tick_cnt = st_r.baud_div;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt - 16'h0001;
		end

		// Write channel: address and data are taken in either order.
		if (awvalid && awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = awaddr[3:0];
		end
		if (wvalid && wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = wdata;
			st_nxt.w_strb = wstrb;
		end
		do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Read channel.
		do_read = arvalid && arready;
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// Receiver.
		if (tick) begin
			case (st_r.rx_st)
				RX_IDLE: begin
					if (st_r.rx_armed && serial_in_pin == LINE_START) begin
						st_nxt.rx_st = RX_START;
						st_nxt.rx_sub = 4'h0;
					end
				end
				RX_START: begin
					st_nxt.rx_sub = st_r.rx_sub + 4'h1;
					if (st_r.rx_sub == HALF_BIT_TICK) begin
						if (serial_in_pin == LINE_START) begin
							st_nxt.rx_st = RX_DATA;
							st_nxt.rx_sub = 4'h0;
							st_nxt.rx_bit = 3'h0;
						end else begin
							st_nxt.rx_st = RX_IDLE;
						end
					end
				end
				RX_DATA: begin
					st_nxt.rx_sub = st_r.rx_sub + 4'h1;
					if (st_r.rx_sub == FULL_BIT_TICK) begin
						// Inverted bits enter at the top, first bit lowest.
						st_nxt.rx_shift =
							{~serial_in_pin, st_r.rx_shift[7:1]};
						st_nxt.rx_bit = st_r.rx_bit + 3'h1;
						if (st_r.rx_bit == LAST_DATA_BIT) begin
							st_nxt.rx_data =
								{~serial_in_pin, st_r.rx_shift[7:1]};
							st_nxt.rx_st = RX_IDLE;
							st_nxt.rx_armed = 1'b0;
						end
					end
				end
				default: begin
					st_nxt.rx_st = RX_IDLE;
				end
			endcase
		end

		// Transmitter.
		if (st_r.tx_st == TX_RUN && tick) begin
			st_nxt.tx_sub = st_r.tx_sub + 4'h1;
			if (st_r.tx_sub == FULL_BIT_TICK) begin
				st_nxt.tx_shift = {LINE_STOP, st_r.tx_shift[FRAME_BITS-1:1]};
				st_nxt.tx_bit = st_r.tx_bit + 4'h1;
				if (st_r.tx_bit == LAST_FRAME_BIT) begin
					st_nxt.tx_st = TX_IDLE;
				end
			end
		end

		// Register write.
		if (do_write) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			if (st_r.aw_addr == BAUD_DIV_OFFSET) begin
				if (st_r.w_strb[0]) begin
					st_nxt.baud_div[7:0] = st_r.w_data[7:0];
				end
				if (st_r.w_strb[1]) begin
					st_nxt.baud_div[15:8] = st_r.w_data[15:8];
				end
			end else if (st_r.aw_addr == SERIAL_DATA_OFFSET) begin
				// Codes go out as written.
				if (st_r.w_strb[0]) begin
					// Stop bits, inverted data, start bit; LSB leaves first.
					st_nxt.tx_shift = {{STOP_BITS{LINE_STOP}},
						~st_r.w_data[7:0], LINE_START};
					st_nxt.tx_st = TX_RUN;
					st_nxt.tx_sub = 4'h0;
					st_nxt.tx_bit = 4'h0;
					st_nxt.tx_done = 1'b0;
				end
			end else if (st_r.aw_addr == LINK_STATUS_OFFSET) begin
				st_nxt.bresp = RESP_OKAY;
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end

		// Register read.
		if (do_read) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			if (rd_addr == BAUD_DIV_OFFSET) begin
				st_nxt.rdata[15:0] = st_r.baud_div;
			end else if (rd_addr == SERIAL_DATA_OFFSET) begin
				st_nxt.rdata[7:0] = st_r.rx_data;
				st_nxt.rx_flag = 1'b0;
				st_nxt.rx_armed = 1'b1;
			end else if (rd_addr == LINK_STATUS_OFFSET) begin
				st_nxt.rdata[STAT_RX_AVAIL] = st_r.rx_flag;
				st_nxt.rdata[STAT_TX_DONE] = st_r.tx_done;
				st_nxt.rdata[STAT_TX_BUSY] = (st_r.tx_st == TX_RUN);
				st_nxt.rdata[STAT_RX_ARMED] = st_r.rx_armed;
				st_nxt.rdata[STAT_IS_RESTART] = cls[0];
				st_nxt.rdata[STAT_IS_TYPE] = cls[1];
				st_nxt.rdata[STAT_IS_ECHO] = cls[2];
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
		end

		// Flag setting comes last so an event beats a same-cycle clear.
		if (tick && st_r.rx_st == RX_DATA
			&& st_r.rx_sub == FULL_BIT_TICK
			&& st_r.rx_bit == LAST_DATA_BIT) begin
			st_nxt.rx_flag = 1'b1;
		end
		if (tick && st_r.tx_st == TX_RUN
			&& st_r.tx_sub == FULL_BIT_TICK
			&& st_r.tx_bit == LAST_FRAME_BIT) begin
			st_nxt.tx_done = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.baud_div <= BAUD_DIV_RESET;
			st_r.rx_st <= RX_IDLE;
			st_r.tx_st <= TX_IDLE;
			st_r.tx_shift <= {FRAME_BITS{LINE_STOP}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign awready = !st_r.aw_got && !st_r.bvalid;
	assign wready = !st_r.w_got && !st_r.bvalid;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = !st_r.rvalid;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	assign serial_out_pin = st_r.tx_shift[0];

endmodule

// File: shared/keyboard_serial_pkg.sv
// Purpose: Shared constants for the keyboard serial link port.
// Assumes: 50 MHz system clock, AXI4-Lite register access.
// Notes: Line levels and register layout live here.

package keyboard_serial_pkg;

	// ==========================================================
	// Clock and bit timing
	// ==========================================================
	localparam int CLK_HZ = 50000000;
	localparam int BAUD_RATE = 31250;
	localparam int OVERSAMPLE = 16;
	localparam logic [15:0] BAUD_DIV_RESET =
		16'(CLK_HZ / (BAUD_RATE * OVERSAMPLE) - 1);
	localparam logic [3:0] HALF_BIT_TICK = 4'h7;
	localparam logic [3:0] FULL_BIT_TICK = 4'hF;

	// ==========================================================
	// Frame format
	// ==========================================================
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 2;
	localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
	localparam logic [3:0] LAST_FRAME_BIT = 4'(FRAME_BITS - 1);
	localparam logic [2:0] LAST_DATA_BIT = 3'(DATA_BITS - 1);
	// The line idles at the stop level; start is the opposite level.
	localparam logic LINE_STOP = 1'b1;
	localparam logic LINE_START = 1'b0;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [3:0] BAUD_DIV_OFFSET = 4'h0;
	localparam logic [3:0] SERIAL_DATA_OFFSET = 4'h4;
	localparam logic [3:0] LINK_STATUS_OFFSET = 4'h8;
	localparam int STAT_RX_AVAIL = 0;
	localparam int STAT_TX_DONE = 1;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_RX_ARMED = 3;
	localparam int STAT_IS_RESTART = 4;
	localparam int STAT_IS_TYPE = 5;
	localparam int STAT_IS_ECHO = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Link codes
	// ==========================================================
	localparam logic [7:0] hard_restart_code = 8'hFF;
	localparam logic [7:0] restart_reply_one = 8'hFE;
	localparam logic [7:0] restart_reply_two = 8'hFD;
	localparam logic [7:0] ack_first_byte = 8'h3F;
	localparam logic [7:0] ack_keys_off_mouse_off = 8'h30;
	localparam logic [7:0] ack_keys_on_mouse_off = 8'h31;
	localparam logic [7:0] ack_keys_off_mouse_on = 8'h32;
	localparam logic [7:0] ack_keys_on_mouse_on = 8'h33;
	localparam logic [7:0] type_code_request = 8'h20;
	localparam logic [7:0] reserved_noop_command = 8'h21;
	localparam logic [7:0] pointer_position_request = 8'h22;
	localparam logic [4:0] lamp_set_command = 5'h00;
	localparam int LAMP_CAPS = 0;
	localparam int LAMP_NUMBER = 1;
	localparam int LAMP_SCROLL = 2;
	localparam logic [3:0] echo_request = 4'h4;
	localparam logic [3:0] echo_reply = 4'hE;
	localparam logic [1:0] type_code_reply = 2'h2;

endpackage

// File: test/keyboard_model.sv
// Purpose: Behavioural keyboard at the far end of the serial link.
// Assumes: Bit length given in clocks by the bench.
// Notes: Answers restart, type and echo codes after a chosen gap.
`timescale 1ns/10ps
module keyboard_model
	import keyboard_serial_pkg::*;
#(
	parameter logic [5:0] KB_TYPE = 6'h15 // Arbitrary type code.
) (
	// Clock and line
	input wire logic clk,
	input wire logic serial_out_pin,
	output logic serial_in_pin,
	// Pacing
	input wire logic [15:0] bit_clks,
	input wire logic [15:0] gap
);
	logic [7:0] got;
	logic [7:0] ans;
	logic reply;
	initial serial_in_pin = LINE_STOP;
	task automatic wait_clks(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic send(input logic [7:0] b);
		serial_in_pin <= LINE_START;
		wait_clks(bit_clks);
		for (int i = 0; i < DATA_BITS; i++) begin
			serial_in_pin <= ~b[i];
			wait_clks(bit_clks);
		end
		serial_in_pin <= LINE_STOP;
		wait_clks(2 * bit_clks);
	endtask
	task automatic pulse(input int n);
		serial_in_pin <= LINE_START;
		wait_clks(n);
		serial_in_pin <= LINE_STOP;
	endtask
	// Replies only to a byte from the host, never unprompted.
	always begin
		@(negedge serial_out_pin);
		wait_clks(bit_clks / 2);
		if (serial_out_pin == LINE_START) begin
			for (int i = 0; i < DATA_BITS; i++) begin
				wait_clks(bit_clks);
				got[i] = ~serial_out_pin;
			end
			wait_clks(2 * bit_clks);
			reply = 1'b1;
			ans = got;
			if (got == type_code_request) begin
				ans = {type_code_reply, KB_TYPE};
			end else if (got[7:4] == echo_request) begin
				ans = {echo_reply, got[3:0]};
			end else if (got < restart_reply_two) begin
				reply = 1'b0;
			end
			wait_clks(gap);
			if (reply) begin
				send(ans);
			end
		end
	end
endmodule

// File: test/keyboard_transceiver_properties.sv
// Purpose: Port-level checks of the keyboard serial link port.
// Assumes: Single clock domain, reset synchronous and active high.
// Notes: Bound to every instance of the transceiver.
`timescale 1ns/10ps
module keyboard_transceiver_properties
	import keyboard_serial_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input wire logic clk, sys_rst,
	// Write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic [1:0] bresp,
	// Read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid, arready, rvalid, rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Serial link
	input wire logic serial_in_pin, serial_out_pin
);
	// ==========================================================
	// Bus handshakes, responses and transmit start
	// ==========================================================
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_taken;
		arvalid && arready;
	endsequence
	a_wr_answer: assert property (wr_both |-> ##2 bvalid)
		else $error("write not answered");
	a_tx_starts: assert property (wr_both ##0 (awaddr == SERIAL_DATA_OFFSET
		&& wstrb[0]) |-> ##[1:3] serial_out_pin == LINE_START)
		else $error("transmit did not start");
	a_wr_unmapped: assert property (wr_both ##0 (awaddr == 4'hC)
		|-> ##2 bvalid && bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	a_aw_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while answering");
	a_ar_refused: assert property (rvalid |-> !arready)
		else $error("read accepted while answering");
	a_rd_data: assert property (rd_taken ##0 (araddr == SERIAL_DATA_OFFSET)
		|=> rvalid && rresp == RESP_OKAY && rdata[31:8] == 24'h0)
		else $error("bad data read answer");
	a_rd_status: assert property (rd_taken ##0 (araddr == LINK_STATUS_OFFSET)
		|=> rvalid && rdata[31:7] == 25'h0 && $onehot0(rdata[6:4]))
		else $error("bad status read answer");
	a_rd_unmapped: assert property (rd_taken ##0 (araddr == 4'hC)
		|=> rvalid && rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind keyboard_transceiver keyboard_transceiver_properties #(.ADDR_W(ADDR_W))
	props (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awprot(awprot),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .wdata(wdata), .wstrb(wstrb),
	.bresp(bresp), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.rresp(rresp), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin));

// File: test/tb_keyboard_transceiver.sv
// Purpose: Self-checking bench for the keyboard serial link port.
// Assumes: Divisor is set to 1, so one bit lasts 32 clocks.
// Notes: Random echo data and reply gaps come from a fixed seed.
`timescale 1ns/10ps
module tb_keyboard_transceiver import keyboard_serial_pkg::*;;
	localparam int BITC = 32;
	localparam logic [5:0] KB_TYPE = 6'h15;
	logic clk = 1'b0, sys_rst = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
	logic arvalid = 1'b0, rready = 1'b1;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, ser_in, ser_out;
	logic [1:0] bresp, rresp;
	logic [15:0] gap = 16'h0;
	logic [7:0] last_rx = 8'h0;
	logic [7:0] c;
	int num_errors = 0, n_checks = 0, cycles = 0;
	always #10 clk = ~clk;
	keyboard_transceiver #(.ADDR_W(4)) dut (.clk(clk), .sys_rst(sys_rst),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .serial_in_pin(ser_in), .serial_out_pin(ser_out));
	keyboard_model #(.KB_TYPE(KB_TYPE)) kb (.clk(clk), .serial_out_pin(ser_out),
		.serial_in_pin(ser_in), .bit_clks(16'(BITC)), .gap(gap));
	// ==========================================================
	// Bus tasks and expectations
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_t, w_t, b_t;
		awaddr <= a;
		wdata <= d;
		awprot <= 3'($urandom);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (b_t !== 1'b1);
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_t, r_t;
		araddr <= a;
		arprot <= 3'($urandom);
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar_t) arvalid <= 1'b0;
		end while (r_t !== 1'b1);
	endtask
	function automatic logic [31:0] stat_of(input logic [7:0] b,
		input logic av, td, bz, ar);
		return {25'h0, b[7:4] == echo_reply, b[7:6] == type_code_reply,
			b == hard_restart_code, ar, bz, td, av};
	endfunction
	function automatic logic [7:0] kb_ans(input logic [7:0] x);
		if (x == type_code_request) return {type_code_reply, KB_TYPE};
		if (x[7:4] == echo_request) return {echo_reply, x[3:0]};
		return x;
	endfunction
	task automatic stat(input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(LINK_STATUS_OFFSET, d, r);
		chk(d, exp);
	endtask
	task automatic send(input logic [7:0] x, input logic ans);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		axi_wr(SERIAL_DATA_OFFSET, 32'(x), r);
		stat(stat_of(last_rx, 1'b0, 1'b0, 1'b1, 1'b1));
		if (!ans) begin
			repeat (14 * BITC) @(posedge clk);
			stat(stat_of(last_rx, 1'b0, 1'b1, 1'b0, 1'b1));
			return;
		end
		n = 0;
		do begin
			axi_rd(LINK_STATUS_OFFSET, d, r);
			n++;
		end while (d[STAT_RX_AVAIL] !== 1'b1 && n < 600);
		if (n >= 600) begin
			$display("unexpected at %0t: got %h expected %h", $time, n, 1);
			num_errors++;
		end
		last_rx = kb_ans(x);
		repeat (3 * BITC) @(posedge clk);
		stat(stat_of(last_rx, 1'b1, 1'b1, 1'b0, 1'b0));
		axi_rd(SERIAL_DATA_OFFSET, d, r);
		chk(d, 32'(last_rx));
		stat(stat_of(last_rx, 1'b0, 1'b1, 1'b0, 1'b1));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			conclude();
		end
	end
	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'hD0D4));
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		axi_rd(BAUD_DIV_OFFSET, d, r);
		chk(d, 32'(BAUD_DIV_RESET));
		stat(32'h0);
		axi_wr(BAUD_DIV_OFFSET, 32'h1, r);
		axi_rd(BAUD_DIV_OFFSET, d, r);
		chk(d, 32'h1);
		axi_wr(4'hC, 32'h0, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_rd(4'hC, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_rd(SERIAL_DATA_OFFSET, d, r);
		stat(stat_of(8'h0, 1'b0, 1'b0, 1'b0, 1'b1));
		$display("test registers finished");
		for (int i = 0; i < 8; i++) begin
			c = {echo_request, 4'($urandom)};
			if (i < 3) c = hard_restart_code - 8'(i);
			if (i == 3) c = type_code_request;
			gap <= (i == 0) ? 16'h0 : 16'($urandom_range(300));
			send(c, 1'b1);
		end
		$display("test replies finished");
		send({lamp_set_command, 3'($urandom)}, 1'b0);
		send(reserved_noop_command, 1'b0);
		for (int i = 0; i < 5; i++) begin
			c = (i == 4) ? ack_first_byte : ack_keys_off_mouse_off + 8'(i);
			send(c, 1'b0);
		end
		$display("test quiet codes finished");
		axi_wr(SERIAL_DATA_OFFSET, 32'(type_code_request), r);
		send({echo_request, 4'($urandom)}, 1'b1);
		$display("test abort finished");
		kb.pulse(BITC / 2 - 4);
		repeat (16 * BITC) @(posedge clk);
		stat(stat_of(last_rx, 1'b0, 1'b1, 1'b0, 1'b1));
		send({echo_request, 4'($urandom)}, 1'b1);
		$display("test false start finished");
		conclude();
	end
endmodule
